// *** core/mots_pkg.sv ***
// Shared constants of the outside-of-thresholds detector: register map, fields, reset values
package mots_pkg;

  // Bus geometry
  localparam int unsigned MOTS_APB_AW   = 10;     // Byte address width on APB
  localparam int unsigned MOTS_APB_DW   = 32;     // APB data width
  localparam int unsigned MOTS_ADDR_LSB = 2;      // Word index starts at this address bit
  localparam int unsigned MOTS_IDX_W    = 8;      // Width of a register index

  // Register indices (byte address is four times the index)
  localparam logic [7:0] MOTS_IDX_STATUS = 8'h2D; // Outside event status, read only
  localparam logic [7:0] MOTS_IDX_UPPER  = 8'h30; // Upper threshold value
  localparam logic [7:0] MOTS_IDX_LOWER  = 8'h31; // Lower threshold value
  localparam logic [7:0] MOTS_IDX_DBCNT  = 8'h32; // Outside debounce count
  localparam logic [7:0] MOTS_IDX_CFG1   = 8'h33; // Detection configuration, first
  localparam logic [7:0] MOTS_IDX_CFG4   = 8'h34; // Sensor configuration, fourth
  localparam logic [7:0] MOTS_IDX_INTMAP = 8'h35; // Interrupt pin routing
  localparam logic [7:0] MOTS_IDX_IRQSTS = 8'h36; // Sticky interrupt status, write one to clear
  localparam logic [7:0] MOTS_IDX_IRQMSK = 8'h37; // Interrupt mask

  // Axis numbering: 0 is Z, 1 is Y, 2 is X
  localparam int unsigned MOTS_AXES   = 3;
  localparam int unsigned MOTS_AXIS_X = 2;

  // Status byte layout
  localparam int unsigned MOTS_ST_ACTIVE = 7;     // Combined outside event active
  localparam int unsigned MOTS_ST_RSVD   = 6;     // Reserved, reads zero
  localparam int unsigned MOTS_ST_W      = 8;     // Status byte width

  // Configuration fields
  localparam int unsigned MOTS_CFG1_LATCH = 3;    // Outside latch enable
  localparam int unsigned MOTS_CFG1_REL   = 4;    // Relative (delta) mode
  localparam int unsigned MOTS_CFG1_W     = 5;
  localparam int unsigned MOTS_CFG4_WAKE  = 0;    // Wake on outside event
  localparam int unsigned MOTS_MAP_ONE    = 0;    // Route active flag to pin one
  localparam int unsigned MOTS_MAP_TWO    = 1;    // Route active flag to pin two
  localparam int unsigned MOTS_MAP_W      = 2;

  // Interrupt events
  localparam int unsigned MOTS_IRQ_RISE = 0;      // Active flag became set
  localparam int unsigned MOTS_IRQ_FALL = 1;      // Active flag became cleared
  localparam int unsigned MOTS_IRQ_W    = 2;

  // Defaults
  localparam int unsigned MOTS_DATA_W    = 12;    // Sample and threshold width
  localparam int unsigned MOTS_DBCNT_W   = 8;     // Debounce count width
  localparam logic [7:0]  MOTS_DBCNT_RST = 8'h00; // Debounce count after reset

endpackage : mots_pkg

// *** core/mots_axis_if.sv ***
// Bundle between the detector core and one axis comparator
`timescale 1ns/1ps
`default_nettype none
interface mots_axis_if #(
  parameter int unsigned W = 12
);
  logic signed [W-1:0] sample;     // Axis sample
  logic signed [W-1:0] upper;      // Upper threshold
  logic signed [W-1:0] lower;      // Lower threshold
  logic                enable;     // Axis takes part
  logic                relative;   // Compare delta instead of sample
  logic                strobe;     // New sample this cycle
  logic                hit;        // Axis is on or outside a threshold
  logic                hit_upper;  // Upper threshold met

  // Comparator side
  modport axis (input sample, upper, lower, enable, relative, strobe, output hit, hit_upper);
  // Core side
  modport core (output sample, upper, lower, enable, relative, strobe, input hit, hit_upper);
endinterface : mots_axis_if
`default_nettype wire

// *** core/mots_axis.sv ***
// One axis comparator: absolute or delta value against upper and lower thresholds
`timescale 1ns/1ps
`default_nettype none
module mots_axis #(
  parameter int unsigned W = 12
) (
  input wire logic     pclk,
  input wire logic     presetn,
  mots_axis_if.axis    bus
);

  logic signed [W:0] ref_q;      // Previous sample, reference for delta mode
  logic signed [W:0] samp_ext;   // Sample widened by one bit
  logic signed [W:0] value;      // Value under test
  logic signed [W:0] upper_ext;  // Widened upper threshold
  logic signed [W:0] lower_ext;  // Widened lower threshold

  assign samp_ext  = {bus.sample[W-1], bus.sample};
  assign upper_ext = {bus.upper[W-1], bus.upper};
  assign lower_ext = {bus.lower[W-1], bus.lower};

  // Reference follows every sample so a delta spans one output-data-rate period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= '0;
    end else if (bus.strobe) begin
      ref_q <= samp_ext;
    end
  end

  // Difference of two W-bit values always fits in W+1 bits
  always_comb begin
    if (bus.relative) begin
      value = samp_ext - ref_q;
    end else begin
      value = samp_ext;
    end
  end

  // Inclusive comparisons on both bounds; only hit is gated by the axis enable, hit_upper is not
  assign bus.hit       = bus.enable & ((value >= upper_ext) | (value <= lower_ext));
  assign bus.hit_upper = (value >= upper_ext);

endmodule : mots_axis
`default_nettype wire

// *** core/mots_top.sv ***
// Outside-of-thresholds detector with APB registers, debounce, wake hold-off and interrupts
//
// Functional notes
// - Active flag needs debounce count of outside samples
// - Active flag zero while all axes inside
// - Outside means at or beyond either threshold
// - Only enabled axes join the evaluation
// - No enabled axis disables detection entirely
// - Wake setting resets wake timer while active
// - No sleep while active flag stays set and wake setting is on
// - X flag zero while X strictly inside; with latching enabled the flag holds until a status read
// - X flag set when X meets threshold
// - X polarity: zero lower, one upper
// - Read-only status byte, fixed layout, resets zero
// - Active flag routable to either interrupt pin
// - Polarity latched on flag set, debounce updates; debounce refreshes it only with latching off
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mots_top
  import mots_pkg::*;
#(
  parameter int unsigned DATA_W  = mots_pkg::MOTS_DATA_W,
  parameter int unsigned DBCNT_W = mots_pkg::MOTS_DBCNT_W
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [mots_pkg::MOTS_APB_AW-1:0]  paddr,
  input  wire logic [mots_pkg::MOTS_APB_DW-1:0]  pwdata,
  output logic      [mots_pkg::MOTS_APB_DW-1:0]  prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              sample_valid,
  input  wire logic signed [DATA_W-1:0]          x_sample,
  input  wire logic signed [DATA_W-1:0]          y_sample,
  input  wire logic signed [DATA_W-1:0]          z_sample,
  output logic                                   interrupt_pin_one,
  output logic                                   interrupt_pin_two,
  output logic                                   irq,
  output logic                                   wake_timer_reset,
  output logic                                   sleep_inhibit
);
  import mots_pkg::*;

  // Refuse widths the register map cannot hold
  if (DATA_W < 2 || DATA_W > 31 || DBCNT_W < 1 || DBCNT_W > MOTS_APB_DW) begin : g_bad_param
    $error("mots_top: unsupported DATA_W or DBCNT_W");
  end

  // Software-visible state
  logic signed [DATA_W-1:0]  upper_threshold_value_q;  // Upper threshold
  logic signed [DATA_W-1:0]  lower_threshold_value_q;  // Lower threshold
  logic [DBCNT_W-1:0]        outside_debounce_count_q; // Debounce count in samples
  logic [MOTS_CFG1_W-1:0]    detect_config_first_q;    // Enables, latch, relative
  logic                      wake_on_outside_event_q;  // Wake hold-off setting
  logic [MOTS_MAP_W-1:0]     pin_map_q;                // Interrupt pin routing
  logic [MOTS_IRQ_W-1:0]     irq_sts_q;                // Sticky events
  logic [MOTS_IRQ_W-1:0]     irq_msk_q;                // Event mask
  logic [MOTS_APB_DW-1:0]    prdata_q;                 // Registered read data

  // Detector state
  logic [MOTS_AXES-1:0]      flag_q;                   // Per-axis outside flags
  logic [MOTS_AXES-1:0]      pol_q;                    // Per-axis polarity flags
  logic                      outside_event_active_q;   // Combined debounced flag
  logic [DBCNT_W-1:0]        cnt_q;                    // Consecutive outside samples
  logic                      wake_pulse_q;             // Wake timer reset pulse

  // Combinational helpers
  logic [MOTS_AXES-1:0]      hit_v;                    // Raw per-axis result
  logic [MOTS_AXES-1:0]      hit_up_v;                 // Upper threshold met
  logic                      any_hit;                  // OR of the enabled axes
  logic [DBCNT_W-1:0]        cnt_next;                 // Count after this sample
  logic                      db_reached;               // Debounce satisfied now
  logic                      latch_en;                 // Latch enable field
  logic [MOTS_ST_W-1:0]      sts_byte;                 // Status byte image
  logic [MOTS_IDX_W-1:0]     idx;                      // Addressed register index
  logic                      addr_ok;                  // Index is mapped
  logic [MOTS_APB_DW-1:0]    rd_mux;                   // Read data selection
  logic                      bus_wr;                   // Write access phase
  logic                      bus_rd;                   // Read access phase
  logic                      sts_rd;                   // Status read completes
  logic [MOTS_IRQ_W-1:0]     irq_ev;                   // Events this cycle
  logic signed [DATA_W-1:0]  samp [MOTS_AXES];         // Samples by axis number

  assign samp[0]  = z_sample;
  assign samp[1]  = y_sample;
  assign samp[2]  = x_sample;
  assign latch_en = detect_config_first_q[MOTS_CFG1_LATCH];

  // Per-axis comparator, flag and polarity
  for (genvar i = 0; i < MOTS_AXES; i++) begin : g_axis
    mots_axis_if #(.W(DATA_W)) ax_if ();

    // Every axis sees the same strobe, so all three compare one sample set
    assign ax_if.sample   = samp[i];
    assign ax_if.upper    = upper_threshold_value_q;
    assign ax_if.lower    = lower_threshold_value_q;
    assign ax_if.enable   = detect_config_first_q[i];
    assign ax_if.relative = detect_config_first_q[MOTS_CFG1_REL];
    assign ax_if.strobe   = sample_valid;
    assign hit_v[i]       = ax_if.hit;
    assign hit_up_v[i]    = ax_if.hit_upper;

    mots_axis #(.W(DATA_W)) u_axis (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (ax_if)
    );

    // Flag follows the comparison; with latching it holds until a status read clears it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_q[i] <= 1'b0;
      end else if (sample_valid) begin
        // A new hit wins over a clear arriving in the same cycle
        // A disabled axis drops even a latched flag, so it never reports an event
        flag_q[i] <= hit_v[i] | (latch_en & ax_if.enable & flag_q[i] & ~(sts_rd & prdata_q[2*i+1]));
      end else if (sts_rd && latch_en && prdata_q[2*i+1]) begin
        flag_q[i] <= 1'b0;
      end
    end

    // Polarity taken when the flag sets, refreshed on debounce in unlatched mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pol_q[i] <= 1'b0;
      end else if (sample_valid && hit_v[i] && (!flag_q[i] || (!latch_en && db_reached))) begin
        pol_q[i] <= hit_up_v[i];
      end
    end

    // Event and polarity pairs, high bit is the event
    assign sts_byte[2*i+1] = flag_q[i];
    assign sts_byte[2*i]   = pol_q[i];
  end

  assign sts_byte[MOTS_ST_RSVD]   = 1'b0;
  assign sts_byte[MOTS_ST_ACTIVE] = outside_event_active_q;

  // Disabled axes report no hit, so no enables means no events at all
  assign any_hit = |hit_v;

  // Saturating run length of outside samples, counting this one
  always_comb begin
    if (!any_hit) begin
      cnt_next = '0;
    end else if (&cnt_q) begin
      cnt_next = cnt_q;
    end else begin
      cnt_next = cnt_q + 1'b1;
    end
  end

  assign db_reached = any_hit & (cnt_next >= outside_debounce_count_q);

  // Debounce counter and combined active flag, advanced once per sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q                  <= '0;
      outside_event_active_q <= 1'b0;
    end else if (sample_valid) begin
      cnt_q                  <= cnt_next;
      outside_event_active_q <= db_reached;
    end
  end

  // Wake timer restart on every sample that leaves the active flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pulse_q <= 1'b0;
    end else begin
      wake_pulse_q <= sample_valid & db_reached & wake_on_outside_event_q;
    end
  end

  assign wake_timer_reset  = wake_pulse_q;
  assign sleep_inhibit     = outside_event_active_q & wake_on_outside_event_q;
  assign interrupt_pin_one = outside_event_active_q & pin_map_q[MOTS_MAP_ONE];
  assign interrupt_pin_two = outside_event_active_q & pin_map_q[MOTS_MAP_TWO];

  // APB decode; zero wait states, read data registered in the setup cycle
  assign idx     = paddr[MOTS_ADDR_LSB +: MOTS_IDX_W];
  assign bus_wr  = psel & penable & pwrite & addr_ok;
  assign bus_rd  = psel & penable & ~pwrite;
  assign sts_rd  = bus_rd & addr_ok & (idx == MOTS_IDX_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_q;

  // Read multiplexer; narrow registers sit in the low bits
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b1;
    case (idx)
      MOTS_IDX_STATUS: rd_mux[MOTS_ST_W-1:0]   = sts_byte;
      MOTS_IDX_UPPER:  rd_mux[DATA_W-1:0]      = upper_threshold_value_q;
      MOTS_IDX_LOWER:  rd_mux[DATA_W-1:0]      = lower_threshold_value_q;
      MOTS_IDX_DBCNT:  rd_mux[DBCNT_W-1:0]     = outside_debounce_count_q;
      MOTS_IDX_CFG1:   rd_mux[MOTS_CFG1_W-1:0] = detect_config_first_q;
      MOTS_IDX_CFG4:   rd_mux[MOTS_CFG4_WAKE]  = wake_on_outside_event_q;
      MOTS_IDX_INTMAP: rd_mux[MOTS_MAP_W-1:0]  = pin_map_q;
      MOTS_IDX_IRQSTS: rd_mux[MOTS_IRQ_W-1:0]  = irq_sts_q;
      MOTS_IDX_IRQMSK: rd_mux[MOTS_IRQ_W-1:0]  = irq_msk_q;
      default:         addr_ok                 = 1'b0;
    endcase
  end

  // Read data captured while psel is up and penable still low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Writable configuration; writes to the status byte are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_threshold_value_q  <= {1'b0, {(DATA_W-1){1'b1}}};
      lower_threshold_value_q  <= {1'b1, {(DATA_W-1){1'b0}}};
      outside_debounce_count_q <= DBCNT_W'(MOTS_DBCNT_RST);
      detect_config_first_q    <= '0;
      wake_on_outside_event_q  <= 1'b0;
      pin_map_q                <= '0;
      irq_msk_q                <= '0;
    end else if (bus_wr) begin
      case (idx)
        MOTS_IDX_UPPER:  upper_threshold_value_q  <= pwdata[DATA_W-1:0];
        MOTS_IDX_LOWER:  lower_threshold_value_q  <= pwdata[DATA_W-1:0];
        MOTS_IDX_DBCNT:  outside_debounce_count_q <= pwdata[DBCNT_W-1:0];
        MOTS_IDX_CFG1:   detect_config_first_q    <= pwdata[MOTS_CFG1_W-1:0];
        MOTS_IDX_CFG4:   wake_on_outside_event_q  <= pwdata[MOTS_CFG4_WAKE];
        MOTS_IDX_INTMAP: pin_map_q                <= pwdata[MOTS_MAP_W-1:0];
        MOTS_IDX_IRQMSK: irq_msk_q                <= pwdata[MOTS_IRQ_W-1:0];
        default:         pin_map_q                <= pin_map_q;
      endcase
    end
  end

  // Sticky events; a new event beats a write-one-to-clear in the same cycle
  assign irq_ev[MOTS_IRQ_RISE] = sample_valid & db_reached & ~outside_event_active_q;
  assign irq_ev[MOTS_IRQ_FALL] = sample_valid & ~db_reached & outside_event_active_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
    end else if (bus_wr && idx == MOTS_IDX_IRQSTS) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[MOTS_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_sts_q <= irq_sts_q | irq_ev;
    end
  end

  assign irq = |(irq_sts_q & irq_msk_q);

  // Checks on the detector
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence outside_sample_s;
    sample_valid && any_hit && (cnt_next >= outside_debounce_count_q);
  endsequence

  sequence x_enter_s;
    sample_valid && hit_v[MOTS_AXIS_X] && !flag_q[MOTS_AXIS_X];
  endsequence

  debounce_rise_a: assert property ($rose(outside_event_active_q) |-> $past(sample_valid && db_reached))
    else $error("active flag rose without a debounced outside run");
  debounce_seq_a: assert property (outside_sample_s |=> outside_event_active_q)
    else $error("active flag missing after debounce reached");
  inside_clear_a: assert property (sample_valid && !any_hit |=> !outside_event_active_q)
    else $error("active flag set while all axes inside");
  x_hit_a: assert property (sample_valid && !detect_config_first_q[MOTS_CFG1_REL]
      && detect_config_first_q[MOTS_AXIS_X] && (x_sample >= upper_threshold_value_q)
      |=> flag_q[MOTS_AXIS_X])
    else $error("x flag not set at upper threshold");
  axis_gate_a: assert property (sample_valid && !detect_config_first_q[MOTS_AXIS_X] |=> !flag_q[MOTS_AXIS_X])
    else $error("disabled x axis raised its flag");
  none_enabled_a: assert property (sample_valid && detect_config_first_q[MOTS_AXES-1:0] == '0
      |=> !outside_event_active_q && flag_q == '0)
    else $error("events raised with all axes disabled");
  wake_reset_a: assert property (outside_sample_s and (sample_valid && wake_on_outside_event_q)
      |=> wake_timer_reset && outside_event_active_q)
    else $error("wake timer not reset while active");
  sleep_hold_a: assert property (outside_event_active_q && wake_on_outside_event_q |-> sleep_inhibit)
    else $error("sleep allowed while active");
  x_inside_a: assert property (sample_valid && !latch_en && !detect_config_first_q[MOTS_CFG1_REL]
      && (x_sample < upper_threshold_value_q) && (x_sample > lower_threshold_value_q)
      |=> !flag_q[MOTS_AXIS_X])
    else $error("x flag set while x inside window");
  x_pol_a: assert property (x_enter_s |=> pol_q[MOTS_AXIS_X] == $past(hit_up_v[MOTS_AXIS_X]))
    else $error("x polarity not taken when flag set");
  status_read_a: assert property (sts_rd |-> prdata[MOTS_ST_RSVD] == 1'b0
      && prdata[MOTS_ST_ACTIVE] == $past(outside_event_active_q))
    else $error("status byte layout wrong");
  pin_route_a: assert property (pin_map_q[MOTS_MAP_TWO] && $rose(outside_event_active_q) |-> interrupt_pin_two)
    else $error("active flag not routed to pin two");

endmodule : mots_top
`default_nettype wire

// *** testbench/mots_host.sv ***
// Host model: APB master that configures the detector and reads its status
`timescale 1ns/1ps
`default_nettype none
module mots_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [9:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 10'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; request held until pready is sampled high, answer taken at that edge
  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave may stretch the access phase; only the bench watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : mots_host
`default_nettype wire

// *** testbench/mots_top_tb.sv ***
// Self-checking bench for the outside-of-thresholds detector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module mots_top_tb;
  import mots_pkg::*;
  logic                    pclk, presetn, sample_valid, wk, err;
  logic                    psel, penable, pwrite, pready, pslverr;
  logic [9:0]              paddr;
  logic [31:0]             pwdata, prdata, rd_data;
  logic signed [11:0]      x_sample, y_sample, z_sample;
  logic                    interrupt_pin_one, interrupt_pin_two, irq, wake_timer_reset, sleep_inhibit;
  int                      fail_count, comparisons;

  // Clock of 25 ns period
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  mots_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  mots_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
    .interrupt_pin_one(interrupt_pin_one), .interrupt_pin_two(interrupt_pin_two), .irq(irq),
    .wake_timer_reset(wake_timer_reset), .sleep_inhibit(sleep_inhibit));

  // Register write
  task wr(input logic [7:0] idx, input logic [31:0] d);
    u_host.xfer(1'b1, idx, d, rd_data, err);
    // The write lands at the access edge; let outputs settle before anyone looks
    @(negedge pclk);
  endtask : wr

  // Register read compared with an expected word
  task rdc(input logic [7:0] idx, input logic [31:0] e);
    u_host.xfer(1'b0, idx, 32'h0000_0000, rd_data, err);
    `CHK(rd_data, e)
  endtask : rdc

  // One output-data-rate sample on all three axes; wake pulse taken the cycle after
  task smp(input logic signed [11:0] x, input logic signed [11:0] y, input logic signed [11:0] z);
    @(posedge pclk);
    sample_valid <= 1'b1;
    x_sample     <= x;
    y_sample     <= y;
    z_sample     <= z;
    @(posedge pclk);
    sample_valid <= 1'b0;
    #1;
    wk = wake_timer_reset;
  endtask : smp

  // Verdict and end of run
  task test_done;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Watchdog well beyond the two hundred or fewer cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done();
  end

  // Test sequence
  initial begin
    presetn = 1'b0;
    sample_valid = 1'b0;
    x_sample = 12'h000;
    y_sample = 12'h000;
    z_sample = 12'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(MOTS_IDX_STATUS, 32'h0000_0000);
    rdc(MOTS_IDX_UPPER, 32'h0000_07FF);
    rdc(MOTS_IDX_LOWER, 32'h0000_0800);
    wr(MOTS_IDX_STATUS, 32'h0000_00FF);
    rdc(MOTS_IDX_STATUS, 32'h0000_0000);
    u_host.xfer(1'b0, 8'h3F, 32'h0000_0000, rd_data, err);
    `CHK(err, 1'b1)
    // Window of -100 to 100, debounce of three, all axes, wake on, pin one
    wr(MOTS_IDX_UPPER, 32'h0000_0064);
    wr(MOTS_IDX_LOWER, 32'h0000_0F9C);
    wr(MOTS_IDX_DBCNT, 32'h0000_0003);
    wr(MOTS_IDX_CFG1, 32'h0000_0007);
    wr(MOTS_IDX_CFG4, 32'h0000_0001);
    wr(MOTS_IDX_INTMAP, 32'h0000_0001);
    smp(12'h064, 12'h000, 12'h000);
    `CHK(wk, 1'b0)
    rdc(MOTS_IDX_STATUS, 32'h0000_0030);
    smp(12'hF9C, 12'h000, 12'h000);
    rdc(MOTS_IDX_STATUS, 32'h0000_0030);
    smp(12'hF9C, 12'h000, 12'h000);
    `CHK(wk, 1'b1)
    rdc(MOTS_IDX_STATUS, 32'h0000_00A0);
    `CHK(sleep_inhibit, 1'b1)
    `CHK({interrupt_pin_two, interrupt_pin_one}, 2'b01)
    `CHK(irq, 1'b0)
    wr(MOTS_IDX_IRQMSK, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(MOTS_IDX_INTMAP, 32'h0000_0002);
    `CHK({interrupt_pin_two, interrupt_pin_one}, 2'b10)
    // Just inside both thresholds
    smp(12'h063, 12'hF9D, 12'h000);
    rdc(MOTS_IDX_STATUS, 32'h0000_0000);
    `CHK(sleep_inhibit, 1'b0)
    rdc(MOTS_IDX_IRQSTS, 32'h0000_0003);
    wr(MOTS_IDX_IRQSTS, 32'h0000_0003);
    rdc(MOTS_IDX_IRQSTS, 32'h0000_0000);
    `CHK(irq, 1'b0)
    // X disabled, no debounce: only Z at the lower threshold counts
    wr(MOTS_IDX_DBCNT, 32'h0000_0000);
    wr(MOTS_IDX_CFG1, 32'h0000_0003);
    smp(12'h1F4, 12'h000, 12'hF9C);
    rdc(MOTS_IDX_STATUS, 32'h0000_0082);
    wr(MOTS_IDX_CFG1, 32'h0000_0000);
    smp(12'h1F4, 12'h1F4, 12'h1F4);
    rdc(MOTS_IDX_STATUS, 32'h0000_0000);
    // Latched X flag survives an inside sample until read
    wr(MOTS_IDX_CFG1, 32'h0000_000C);
    smp(12'h0C8, 12'h000, 12'h000);
    smp(12'h000, 12'h000, 12'h000);
    rdc(MOTS_IDX_STATUS, 32'h0000_0030);
    rdc(MOTS_IDX_STATUS, 32'h0000_0010);
    // Relative mode: large sample with small delta is inside, falling delta is outside
    wr(MOTS_IDX_CFG1, 32'h0000_0014);
    smp(12'h05A, 12'h000, 12'h000);
    smp(12'h0B4, 12'h000, 12'h000);
    rdc(MOTS_IDX_STATUS, 32'h0000_0010);
    smp(12'h03C, 12'h000, 12'h000);
    rdc(MOTS_IDX_STATUS, 32'h0000_00A0);
    test_done();
  end
endmodule : mots_top_tb
`default_nettype wire
